// file: shared/xdp_pkg.sv
// Constants of the microcode extension datapath: field positions,
// encodings and register map.
// Assumes the 80-bit extended microword layout of the base processor.
`default_nettype none
package xdp_pkg;
    // ------------------------------------------------------------
    // Microword layout (absolute bit positions)
    // ------------------------------------------------------------
    localparam int XU_LSB      = 56;  // Extension word is bits 79:56
    localparam int XU_W        = 24;
    localparam int DESTINATION_FIELD_LSB    = 62;  // destination_field 63:62
    localparam int MSC_LSB     = 59;  // misc_control_field 61:59
    localparam int NXT_LSB     = 48;  // next_address_field 58:48
    localparam int NXT_W       = 11;
    localparam int CLK_LSB     = 45;  // Clock field 47:45
    localparam int ALU_LSB     = 24;  // ALU function field 28:24
    localparam int LIT_LSB     = 64;  // Literal 79:64
    localparam int SC_LSB      = 72;  // shift_count_field 75:72
    localparam int LML_LSB     = 64;  // left_mask_limit 67:64
    localparam int RML_LSB     = 68;  // right_mask_limit 71:68
    localparam int SHIFT_COMBINE_FIELD_LSB    = 78;  // shift_combine_field 79:78
    localparam int BR_W        = 3;   // Branch bits into the word
    localparam int CS_AW       = 10;  // RAM control store address
    localparam int RAM_SEL_BIT = 10;  // Pointer bit choosing RAM
    localparam int SLICES      = 5;
    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DST_IDLE  = 2'b00,
        DST_RD    = 2'b01,
        DST_STACK = 2'b10,
        DST_RAM   = 2'b11
    } destination_field_t;
    localparam logic [2:0] SRC_STACK = 3'h0;
    localparam logic [2:0] SRC_SP    = 3'h1;
    localparam logic [2:0] SRC_LIT   = 3'h2;
    localparam logic [2:0] SRC_RAM0  = 3'h3;
    localparam logic [2:0] SRC_LDSP  = 3'h7;  // With DST_IDLE
    localparam logic [1:0] SHIFT_COMBINE_FIELD_D    = 2'b11;  // Write from D input
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] XU_OFF     = 8'h08;
    localparam logic [1:0] CTRL_RST   = 2'b00;
    localparam int CTRL_FREEZE = 0;
    localparam int CTRL_CLRSTP = 1;
    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
endpackage : xdp_pkg
`default_nettype wire

// file: rtl/xdp_rotator.sv
// 16-bit barrel rotator, left by a 4-bit count.
// Assumes a purely combinational use inside one microcycle.
`default_nettype none
module xdp_rotator (
    // Data in and count
    input  wire logic [15:0] din,
    input  wire logic [3:0]  amt,
    // Rotated data
    output logic      [15:0] dout
);
    logic [31:0] dbl;

    // Doubled word shifted; upper half is the rotation
    assign dbl  = {din, din} << amt;
    assign dout = dbl[31:16];
endmodule : xdp_rotator
`default_nettype wire

// file: rtl/xdp_mask_gen.sv
// Field-extraction mask from left and right limits.
// Assumes left limit names the upper bit, right the lower bit.
`default_nettype none
module xdp_mask_gen (
    // Limits
    input  wire logic [3:0]  left_lim,
    input  wire logic [3:0]  right_lim,
    // Mask
    output logic      [15:0] mask
);
    // One bit per position; an inverted pair gives an empty mask
    for (genvar i = 0; i < 16; i++) begin : g_bit
        assign mask[i] = (4'(i) <= left_lim) && (4'(i) >= right_lim);
    end
endmodule : xdp_mask_gen
`default_nettype wire

// file: rtl/microcode_extension_datapath.sv
// Extension datapath of a microprogrammed 16-bit processor, with an
// AXI4-Lite slave for control and observation.
// Assumes the sequencer supplies the pointer and PROM word each cycle.
`default_nettype none
module microcode_extension_datapath
    import xdp_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Sequencer side
    input  wire logic [10:0] microprogram_pointer,
    input  wire logic [79:0] prom_word,
    input  wire logic [15:0] d_data,
    output logic      [15:0] rd_bus_data,
    output logic             rd_bus_en,
    output logic      [10:0] expansion_branch_control,
    output logic      [10:0] next_address,
    output logic      [4:0]  alu_function,
    output logic             clock_stop,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ------------------------------------------------------------
    // Storage and decoded fields
    // ------------------------------------------------------------
    logic [79:0]     cs_ram [1024];
    logic [15:0]     stack [16];
    logic [XU_W-1:0] xu_r;
    logic [7:0]      nxt_lo_r;
    logic [4:0]      alu_r;
    logic [3:0]      sp_r;
    logic            stop_r;
    logic [1:0]      ctrl_r;
    logic [79:0]     ram_word, sel_word;
    logic [CS_AW-1:0] ram_addr;
    logic [15:0]     src, wr_data, rot, mask, stack_out, comb;
    logic            use_stack;
    destination_field_t           destination_field;
    logic [2:0]      misc_control_field;
    logic            xu_load;
    // AXI4-Lite write capture, read by the stop clear below
    logic            aw_held_r, w_held_r, wr_go;
    logic [7:0]      s_axi_awaddr_r;
    logic [31:0]     w_data_r;
    logic [3:0]      w_strb_r;

    // Fields sit inside the extension word, offset by its base bit
    assign destination_field = destination_field_t'(xu_r[DESTINATION_FIELD_LSB-XU_LSB +: 2]);
    assign misc_control_field  = xu_r[MSC_LSB-XU_LSB +: 3];

    function automatic logic [3:0] nib(input logic [XU_W-1:0] w,
                                       input int lsb);
        nib = w[lsb-XU_LSB +: 4];
    endfunction : nib

    // ------------------------------------------------------------
    // Source select, write data, rotate, mask
    // ------------------------------------------------------------
    // RAM slices 0..4 follow the literal and pointer choices
    always_comb begin
        case (misc_control_field)
            SRC_STACK: src = stack_out;
            SRC_SP:    src = {12'h000, sp_r};
            SRC_LIT:   src = xu_r[LIT_LSB-XU_LSB +: 16];
            default:   src = ram_word[16*(misc_control_field-SRC_RAM0) +: 16];
        endcase
    end

    // Combine field 11 writes from D, else from the source mux
    assign wr_data = (xu_r[SHIFT_COMBINE_FIELD_LSB-XU_LSB +: 2] == SHIFT_COMBINE_FIELD_D) ?
                     d_data : src;

    xdp_rotator u_rot (
        .din  (src),
        .amt  (nib(xu_r, SC_LSB)),
        .dout (rot)
    );

    xdp_mask_gen u_mask (
        .left_lim  (nib(xu_r, LML_LSB)),
        .right_lim (nib(xu_r, RML_LSB)),
        .mask      (mask)
    );

    // Combine bit 0 picks extract or merge-with-ones
    assign comb = xu_r[SHIFT_COMBINE_FIELD_LSB-XU_LSB] ? (rot | ~mask)
                                         : (rot & mask);
    assign expansion_branch_control = comb[10:0];

    // ------------------------------------------------------------
    // Stack, pointer and control store
    // ------------------------------------------------------------
    assign stack_out = stack[sp_r];
    // Stack addresses RAM for RAM writes and RAM-slice reads
    assign use_stack = (destination_field == DST_RAM) || (misc_control_field >= SRC_RAM0);
    assign ram_addr  = use_stack ? stack_out[CS_AW-1:0]
                     : microprogram_pointer[CS_AW-1:0];
    assign ram_word  = cs_ram[ram_addr];
    assign sel_word  = microprogram_pointer[RAM_SEL_BIT] ?
                       ram_word : prom_word;

    // Stack write; no reset, contents are undefined at power-up
    always_ff @(posedge aclk) begin
        if (destination_field == DST_STACK) begin
            stack[sp_r] <= wr_data;
        end
    end

    // RAM write goes to the slice named by the source field
    always_ff @(posedge aclk) begin
        if (destination_field == DST_RAM && misc_control_field >= SRC_RAM0) begin
            cs_ram[ram_addr][16*(misc_control_field-SRC_RAM0) +: 16] <= wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_r <= 4'h0;
        end else if (destination_field == DST_IDLE && misc_control_field == SRC_LDSP) begin
            sp_r <= nib(xu_r, SC_LSB);
        end
    end

    // ------------------------------------------------------------
    // Extension word register and sequencing
    // ------------------------------------------------------------
    // A word is taken only while neither frozen nor stopped
    assign xu_load = !ctrl_r[CTRL_FREEZE] && !stop_r;

    // Freeze holds the word so software can inspect a stuck cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xu_r     <= '0;
            nxt_lo_r <= 8'h00;
            alu_r    <= 5'h00;
        end else if (!ctrl_r[CTRL_FREEZE] && !stop_r) begin
            xu_r     <= sel_word[79:XU_LSB]
                      | {21'h0, comb[BR_W-1:0]};
            nxt_lo_r <= sel_word[NXT_LSB +: 8];
            alu_r    <= sel_word[ALU_LSB +: 5];
        end
    end
    assign next_address = {xu_r[2:0], nxt_lo_r};
    assign alu_function = alu_r;

    // Stop sets only as its word loads, so a frozen restart holds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_r <= 1'b0;
        end else if (sel_word[CLK_LSB] && xu_load) begin
            stop_r <= 1'b1;
        end else if (s_axi_bvalid == 1'b0 && wr_go &&
                     s_axi_awaddr_r == CTRL_OFF &&
                     w_data_r[CTRL_CLRSTP]) begin
            stop_r <= 1'b0;
        end
    end
    assign clock_stop = stop_r;

    // Register-data bus output comes from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_bus_data <= 16'h0000;
            rd_bus_en   <= 1'b0;
        end else begin
            rd_bus_data <= (destination_field == DST_RD) ? comb : 16'h0000;
            rd_bus_en   <= (destination_field == DST_RD);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready  = !w_held_r;
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

    // Address and data are caught independently, in any order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r      <= 1'b0;
            w_held_r       <= 1'b0;
            s_axi_awaddr_r <= 8'h00;
            w_data_r       <= 32'h0000_0000;
            w_strb_r       <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r      <= 1'b1;
                s_axi_awaddr_r <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Control register and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r       <= CTRL_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OK;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr_r == CTRL_OFF) ?
                            RESP_OK : RESP_ERR;
            if (s_axi_awaddr_r == CTRL_OFF && w_strb_r[0]) begin
                ctrl_r[CTRL_FREEZE] <= w_data_r[CTRL_FREEZE];
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Reads: status shows pointer, stop and current source select
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OK;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OK;
            case (s_axi_araddr)
                CTRL_OFF:   s_axi_rdata <= {31'h0, ctrl_r[0]};
                STATUS_OFF: s_axi_rdata <= {24'h0, misc_control_field, stop_r, sp_r};
                XU_OFF:     s_axi_rdata <= {8'h00, xu_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_ERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    src_sel_sp_a: assert property (
        misc_control_field == SRC_SP |-> src == {12'h000, sp_r})
        else $error("source select pointer wrong");
    stack_write_a: assert property (
        destination_field == DST_STACK && xu_r[79-XU_LSB -: 2] != SHIFT_COMBINE_FIELD_D
        |=> stack[$past(sp_r)] == $past(src))
        else $error("stack not written from source");
    rd_bus_a: assert property (
        destination_field == DST_RD |=> rd_bus_en &&
        rd_bus_data == $past(comb))
        else $error("register bus word wrong");
    sp_load_a: assert property (
        destination_field == DST_IDLE && misc_control_field == SRC_LDSP
        |=> sp_r == $past(xu_r[SC_LSB-XU_LSB +: 4]))
        else $error("stack pointer not loaded");
    ram_addr_a: assert property (
        use_stack |-> ram_addr == stack_out[CS_AW-1:0])
        else $error("control store address not from stack");
    xu_load_a: assert property (
        !ctrl_r[0] && !stop_r |=> xu_r[23:3] == $past(sel_word[79:59]))
        else $error("extension word not loaded");
    next_addr_a: assert property (
        $past(aresetn) && xu_load |=> next_address ==
        ($past(sel_word[58:48]) | {$past(comb[2:0]), 8'h00}))
        else $error("next address wrong");
    clk_stop_a: assert property (
        sel_word[CLK_LSB] && xu_load |=> clock_stop [*2])
        else $error("clock not stopped");
    bvalid_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");

    stack_wr_c:  cover property (destination_field == DST_STACK);
    rd_drive_c:  cover property (destination_field == DST_RD ##1 rd_bus_en);
    stop_c:      cover property ($rose(stop_r));
    axi_write_c: cover property (wr_go);
endmodule : microcode_extension_datapath
`default_nettype wire

// file: test/xdp_sequencer_model.sv
// Behavioural model of the base sequencer: PROM store and D register.
// Assumes the datapath's next_address register is the fetch pointer.
`default_nettype none
module xdp_sequencer_model (
    // Clock
    input  wire logic        aclk,
    // Pointer from the datapath
    input  wire logic [10:0] next_address,
    // Fetch side
    output logic      [10:0] microprogram_pointer,
    output logic      [79:0] prom_word,
    output logic      [15:0] d_data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [79:0] rom [0:15];
    logic [15:0] dtab [0:15];
    logic [3:0]  exec_r;

    // No counter here: fetch follows the next-address register
    // Only the PROM is modelled, so the RAM select bit stays clear
    assign microprogram_pointer = {1'b0, next_address[9:0]};
    assign prom_word            = rom[next_address[3:0]];

    // D register value belongs to the word now executing
    always_ff @(posedge aclk) begin
        exec_r <= next_address[3:0];
    end
    assign d_data = dtab[exec_r];
endmodule : xdp_sequencer_model
`default_nettype wire

// file: test/tb_microcode_extension_datapath.sv
// Self-checking bench: two microprograms run through the sequencer
// model, registers are inspected over AXI4-Lite.
// Assumes next_address clears in reset, so fetch starts at word 0.
`default_nettype none
module tb_microcode_extension_datapath
    import xdp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        aclk, aresetn, rd_bus_en, clock_stop;
    logic [10:0] microprogram_pointer, next_address;
    logic [10:0] expansion_branch_control;
    logic [79:0] prom_word, stopw;
    logic [15:0] d_data, rd_bus_data, v [5];
    logic [4:0]  alu_function;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [15:0] rq [$];
    int          seed = 78435;
    int          cycles = 0;
    int          fail_count = 0;
    int          num_checks = 0;

    microcode_extension_datapath dut (
        .aclk, .aresetn, .microprogram_pointer, .prom_word, .d_data,
        .rd_bus_data, .rd_bus_en, .expansion_branch_control,
        .next_address, .alu_function, .clock_stop,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    xdp_sequencer_model seq (
        .aclk, .next_address, .microprogram_pointer, .prom_word, .d_data);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always #5 aclk = ~aclk;

    task automatic end_sim();
        $display("checks %0d, errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : check

    // Rotate left, then mask bits right..left, or fill outside them
    function automatic logic [15:0] comb(input logic [15:0] s, l);
        logic [15:0] rt, m;
        rt = (s << l[11:8]) | (s >> (16 - l[11:8]));
        for (int i = 0; i < 16; i++) m[i] = i >= l[7:4] && i <= l[3:0];
        return l[14] ? (rt | ~m) : (rt & m);
    endfunction : comb

    // Microword: literal, destination_field, misc, next, clock field, random rest
    function automatic logic [79:0] mk(input logic [1:0] ds,
        input logic [2:0] ms, input logic [15:0] lt, input logic [3:0] nx,
        input logic st);
        logic [63:0] rn;
        rn = {$random(seed), $random(seed)};
        return {lt, ds, ms, 7'd0, nx, 2'b00, st, rn[44:0]};
    endfunction : mk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd,
                          output logic [1:0] rs);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd,
                          output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    // Run until the stop word halts the clock, then let results drain
    task automatic run_to_stop();
        do @(posedge aclk); while (clock_stop !== 1'b1);
        repeat (4) @(posedge aclk);
        check(32'(rq.size()), 32'h0000_0000);
    endtask : run_to_stop

    // Every bus word is matched against the oldest note
    always @(posedge aclk) begin
        if (rd_bus_en === 1'b1) begin
            check({16'h0000, rd_bus_data}, rq.size() ?
                  {16'h0000, rq.pop_front()} : 32'hFFFF_FFFF);
        end
    end

    // Hang guard, far beyond the fewer than a hundred cycles needed
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        // Program one: pointer, stack, RAM slices, then stop
        seq.rom[0] = mk(DST_IDLE, SRC_LDSP, 16'h0500, 4'd1, 1'b0);
        seq.rom[1] = mk(DST_STACK, SRC_LIT, 16'h0123, 4'd2, 1'b0);
        for (int k = 0; k < 5; k++) begin
            v[k] = 16'($random(seed));
            seq.dtab[2+k] = v[k];
            seq.rom[2+k] = mk(DST_RAM, 3'(k + 3), 16'hC000, 4'(k + 3), 1'b0);
            seq.rom[7+k] = mk(DST_RD, 3'(k + 3), 16'h000F, 4'(k + 8), 1'b0);
            rq.push_back(v[k]);
        end
        seq.rom[12] = mk(DST_RD, SRC_STACK, 16'h000F, 4'd13, 1'b0);
        rq.push_back(16'h0123);
        seq.rom[13] = mk(DST_RD, SRC_SP, 16'h000F, 4'd14, 1'b0);
        rq.push_back(16'h0005);
        stopw = mk(DST_IDLE, SRC_LIT, 16'h00F0, 4'd0, 1'b1);
        seq.rom[14] = stopw;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        run_to_stop();
        axi_rd(STATUS_OFF, d, r);
        check(d, 32'h0000_0055);
        axi_rd(XU_OFF, d, r);
        check(d, {8'h00, stopw[79:59], 3'b101});
        check(32'(next_address), 32'h0000_0500);
        check(32'(alu_function), 32'(stopw[28:24]));
        check(32'(expansion_branch_control), 32'h0000_0000);
        axi_wr(STATUS_OFF, 32'hFFFF_FFFF, r);
        check(32'(r), 32'(RESP_ERR));
        axi_rd(8'h0C, d, r);
        check({d[29:0], r}, {30'h0, RESP_ERR});
        // Freeze while clearing the stop: nothing may load
        axi_wr(CTRL_OFF, 32'h0000_0003, r);
        check(32'(clock_stop), 32'h0000_0000);
        repeat (4) @(posedge aclk);
        check(32'(alu_function), 32'(stopw[28:24]));
        axi_rd(CTRL_OFF, d, r);
        check(d, 32'h0000_0001);
        // Program two: random literals through rotator and mask
        for (int i = 0; i < 14; i++) begin
            d = $random(seed);
            seq.rom[i] = mk(d[16] ? DST_RD : DST_IDLE, SRC_LIT, d[15:0],
                            4'(i + 1), 1'b0);
            if (d[16]) rq.push_back(comb(d[15:0], d[15:0]));
        end
        axi_wr(CTRL_OFF, 32'h0000_0000, r);
        run_to_stop();
        end_sim();
    end
endmodule : tb_microcode_extension_datapath
`default_nettype wire
